// File: rtl/drc_if.sv
// interface: request path between interval timer and refresh sequencer
interface drc_tick_if;
   logic       tick;
   logic [1:0] ivl_code;
   modport timer (output tick, input ivl_code);
   modport seq   (input tick, output ivl_code);
endinterface

// File: rtl/drc_pkg.sv
// package: constants and types for the dram refresh controller
package drc_pkg;
   localparam logic [7:0] DRC_CTRL_ADDR     = 8'h36;
   localparam logic [7:0] DRC_CTRL_RESET    = 8'hC0;
   localparam int         DRC_ON_BIT        = 7;
   localparam int         DRC_WAIT_BIT      = 6;
   localparam int         DRC_IVL_HI_BIT    = 1;
   localparam int         DRC_IVL_LO_BIT    = 0;
   localparam logic [7:0] DRC_CTRL_WMASK    = 8'hC3;
   localparam logic [6:0] DRC_IVL_10        = 7'd10;
   localparam logic [6:0] DRC_IVL_20        = 7'd20;
   localparam logic [6:0] DRC_IVL_40        = 7'd40;
   localparam logic [6:0] DRC_IVL_80        = 7'd80;
   localparam logic [6:0] DRC_ONE7          = 7'd1;
   localparam int         DRC_ADDR_W        = 8;
   localparam logic [1:0] DRC_LEN_SHORT     = 2'd1;
   localparam logic [1:0] DRC_LEN_LONG      = 2'd2;
   localparam logic [7:0] DRC_ADDR_ONE      = 8'h01;

   typedef enum logic [2:0] {
      DRC_IDLE    = 3'b001,
      DRC_CYCLE   = 3'b010,
      DRC_WAIT    = 3'b100
   } drc_state_e;
endpackage

// File: rtl/drc_refresh.sv
// file holds the dram refresh controller top
import drc_pkg::*;

module drc_refresh (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] io_addr,
   input  wire logic [7:0] io_wdata,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   output logic      [7:0] io_rdata,
   output logic            io_rdata_valid,
   input  wire logic       bus_request_in,
   input  wire logic       sleep_mode,
   input  wire logic       wait_active,
   input  wire logic       cycle_end,
   output logic            refresh_strobe,
   output logic            refresh_wait_state,
   output logic      [7:0] refresh_addr,
   output logic            refresh_busy
);
   import drc_pkg::*;

   drc_tick_if tk ();

   logic [7:0]  refresh_control_reg;
   logic [7:0]  refresh_control_next;
   logic        pend_reg;
   logic        pend_next;
   logic        slept_reg;
   logic        slept_next;
   drc_state_e  state_reg;
   drc_state_e  state_next;
   logic [1:0]  len_reg;
   logic [1:0]  len_next;
   logic        phase_reg;
   logic        phase_next;
   logic [7:0]  addr_reg;
   logic [7:0]  addr_next;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;
   logic        rvalid_reg;
   logic        rvalid_next;
   logic        refresh_on;
   logic        refresh_extra_wait;
   logic        hold_off;
   logic        start;

   // io register decode, used by both read and write paths
   function automatic logic drc_hit(input logic [7:0] a);
      drc_hit = (a == DRC_CTRL_ADDR);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register fields
   assign refresh_on         = refresh_control_reg[DRC_ON_BIT];
   assign refresh_extra_wait = refresh_control_reg[DRC_WAIT_BIT];
   assign tk.ivl_code = {refresh_control_reg[DRC_IVL_HI_BIT],
                         refresh_control_reg[DRC_IVL_LO_BIT]};

   drc_timer u_timer (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .tk      (tk)
   );

   ////////////////////////////////////////////////////////////////////////
   // register port; unused bits read as zero since writes mask them off
   always_comb begin
      refresh_control_next = refresh_control_reg;
      rdata_next           = rdata_reg;
      rvalid_next          = 1'b0;
      if (io_wr && drc_hit(io_addr)) begin
         refresh_control_next = io_wdata & DRC_CTRL_WMASK;
      end
      if (io_rd && drc_hit(io_addr)) begin
         rdata_next  = refresh_control_reg;
         rvalid_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         refresh_control_reg <= DRC_CTRL_RESET;
         rdata_reg           <= '0;
         rvalid_reg          <= 1'b0;
      end else begin
         refresh_control_reg <= refresh_control_next;
         rdata_reg           <= rdata_next;
         rvalid_reg          <= rvalid_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timing of one refresh, in clocks counted from the start decision:
   //   edge 0: start is seen, the sequencer leaves idle
   //   clock 1: strobe high, address on the row lines, phase 0
   //   clock 2: strobe high, phase 1
   //   clock 3: only with the extra wait bit set, wait state high
   //   next edge: back to idle, row address steps by one
   // the extra wait choice is frozen at start, so a register write that
   // lands in mid-cycle only affects the next refresh, never a running one
   //
   // hold-off handling differs by cause:
   //   bus release: the timer keeps going but due requests are dropped,
   //                so the first refresh after bus return is paced by the
   //                timer and has no fixed relation to the bus exchange
   //   sleep: the newest due request waits in the pending latch and is
   //          served right after the first machine cycle past wake-up
   //   wait states: the pending request simply waits for the wait to end
   //
   // limitation: only one request is kept, so at any interval setting a hold-off
   // longer than one interval can cost a refresh; the row counter still stays gap
   // free, since it only moves when a refresh really ran
   ////////////////////////////////////////////////////////////////////////
   // request latch and sequencer
   // a request that cannot be served is kept in one latch unless the bus is away; a newer one
   // just overwrites it, so missed requests never queue up
   assign hold_off = bus_request_in || sleep_mode || wait_active;
   assign start    = (state_reg == DRC_IDLE) && refresh_on && pend_reg
                     && !hold_off && cycle_end && !slept_reg;

   always_comb begin
      pend_next  = pend_reg;
      slept_next = slept_reg;
      state_next = state_reg;
      len_next   = len_reg;
      phase_next = phase_reg;
      addr_next  = addr_reg;
      // after sleep wait for the end of the first machine cycle
      if (sleep_mode) begin
         slept_next = 1'b1;
      end else if (slept_reg && cycle_end) begin
         slept_next = 1'b0;
      end
      if (start) begin
         pend_next = 1'b0;
      end
      if (tk.tick && refresh_on) begin
         pend_next = 1'b1;
      end
      if (!refresh_on) begin
         pend_next = 1'b0;
      end
      // requests due while the bus is away are dropped, timer keeps pace
      if (bus_request_in) begin
         pend_next = 1'b0;
      end
      case (state_reg)
         DRC_IDLE: begin
            if (start) begin
               state_next = DRC_CYCLE;
               len_next   = refresh_extra_wait ? DRC_LEN_LONG : DRC_LEN_SHORT;
            end
         end
         DRC_CYCLE: begin
            // two clocks here for every refresh, then wait or back to idle
            if (!phase_reg) begin
               phase_next = 1'b1;
            end else begin
               phase_next = 1'b0;
               if (len_reg == DRC_LEN_LONG) begin
                  state_next = DRC_WAIT;
               end else begin
                  state_next = DRC_IDLE;
                  addr_next  = addr_reg + DRC_ADDR_ONE;
               end
            end
         end
         DRC_WAIT: begin
            state_next = DRC_IDLE;
            addr_next  = addr_reg + DRC_ADDR_ONE;
         end
         default: state_next = DRC_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_reg  <= 1'b0;
         slept_reg <= 1'b0;
         state_reg <= DRC_IDLE;
         len_reg   <= DRC_LEN_SHORT;
         phase_reg <= 1'b0;
         addr_reg  <= '0;
      end else begin
         pend_reg  <= pend_next;
         slept_reg <= slept_next;
         state_reg <= state_next;
         len_reg   <= len_next;
         phase_reg <= phase_next;
         addr_reg  <= addr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign refresh_busy       = (state_reg != DRC_IDLE);
   assign refresh_strobe     = refresh_busy;
   assign refresh_wait_state = (state_reg == DRC_WAIT);
   assign refresh_addr       = addr_reg;
   assign io_rdata           = rdata_reg;
   assign io_rdata_valid     = rvalid_reg;
endmodule

// File: rtl/drc_timer.sv
// file holds the refresh interval timer
module drc_timer
   import drc_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic reset_n,
   drc_tick_if.timer tk
);
   logic [6:0] cnt_reg;
   logic [6:0] cnt_next;
   logic       tick_reg;
   logic       tick_next;

   // decode of the interval code to a count of clock states
   function automatic logic [6:0] drc_ivl(input logic [1:0] code);
      case (code)
         2'b00:   drc_ivl = DRC_IVL_10;
         2'b01:   drc_ivl = DRC_IVL_20;
         2'b10:   drc_ivl = DRC_IVL_40;
         default: drc_ivl = DRC_IVL_80;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // counts free, even during bus release or sleep, so requests keep pace
   always_comb begin
      tick_next = 1'b0;
      cnt_next  = cnt_reg + DRC_ONE7;
      if (cnt_reg + DRC_ONE7 >= drc_ivl(tk.ivl_code)) begin
         cnt_next  = '0;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tk.tick = tick_reg;
endmodule

// File: tb/drc_dram_model.sv
// model: dram side that counts refresh cycles and keeps the last row
module drc_dram_model (
   input  wire logic       ref_clk,
   input  wire logic       refresh_strobe,
   input  wire logic [7:0] refresh_addr,
   output int              n_refresh = 0,
   output logic      [7:0] last_row
);
   logic strobe_d = 1'b0;
   // one row per strobe pulse, taken on its leading edge
   always @(posedge ref_clk) begin
      strobe_d <= refresh_strobe;
      if (refresh_strobe && !strobe_d) begin
         n_refresh <= n_refresh + 1;
         last_row  <= refresh_addr;
      end
   end
endmodule

// File: tb/drc_refresh_sva.sv
// checker: port properties of the refresh controller
module drc_refresh_sva
   import drc_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       reset_n,
   input wire logic [7:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic       io_rdata_valid,
   input wire logic       bus_request_in,
   input wire logic       sleep_mode,
   input wire logic       wait_active,
   input wire logic       cycle_end,
   input wire logic       refresh_strobe,
   input wire logic       refresh_wait_state,
   input wire logic [7:0] refresh_addr,
   input wire logic       refresh_busy
);
   logic [7:0] cfg_reg;
   // shadow of the control register, rebuilt from port traffic only
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) cfg_reg <= DRC_CTRL_RESET;
      else if (io_wr && io_addr == DRC_CTRL_ADDR) cfg_reg <= io_wdata & DRC_CTRL_WMASK;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////
   hold_off_a: assert property ($rose(refresh_strobe) |->
      $past(cycle_end) && !$past(bus_request_in) && !$past(sleep_mode) && !$past(wait_active))
      else $error("bad start");
   refresh_on_a: assert property ($rose(refresh_strobe) |-> $past(cfg_reg[DRC_ON_BIT]))
      else $error("refresh while off");
   short_len_a: assert property ($rose(refresh_strobe) && !cfg_reg[DRC_WAIT_BIT] |->
      (refresh_strobe && !refresh_wait_state)[*2] ##1 !refresh_strobe) else $error("short len");
   long_len_a: assert property ($rose(refresh_strobe) && cfg_reg[DRC_WAIT_BIT] |->
      (refresh_strobe && !refresh_wait_state)[*2] ##1 (refresh_strobe && refresh_wait_state)
      ##1 !refresh_strobe) else $error("long len");
   addr_step_a: assert property ($fell(refresh_strobe) |->
      refresh_addr == $past(refresh_addr) + DRC_ADDR_ONE) else $error("row not advanced");
   addr_still_a: assert property (!$fell(refresh_strobe) |-> $stable(refresh_addr))
      else $error("row moved");
   rd_answer_a: assert property (io_rd && io_addr == DRC_CTRL_ADDR |=> io_rdata_valid)
      else $error("read unanswered");
   rd_data_a: assert property (io_rdata_valid |-> io_rdata == $past(cfg_reg))
      else $error("read data");
   cover property ($rose(refresh_strobe) && cfg_reg[DRC_WAIT_BIT]);
   cover property ($rose(refresh_strobe) && !cfg_reg[DRC_WAIT_BIT]);
   cover property ($fell(sleep_mode) ##[1:6] $rose(refresh_strobe));
endmodule

bind drc_refresh drc_refresh_sva i_sva (.*);

// File: tb/drc_refresh_test.sv
// testbench: directed scenarios for the dram refresh controller
module drc_refresh_test
   import drc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       ref_clk, reset_n, io_wr, io_rd, io_rdata_valid, bus_request_in, sleep_mode;
   logic       wait_active, cycle_end, refresh_strobe, refresh_wait_state, refresh_busy;
   logic [7:0] io_addr, io_wdata, io_rdata, refresh_addr, last_row;
   int         err_count, n_compared, n_refresh;
   drc_refresh i_dut (.*);
   drc_dram_model i_dram (.*);
   ////////////////////////////////////////////////////////////
   task automatic stop_test(bit hung);
      if (hung) err_count++;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one register access, strobe held across exactly one rising edge
   task automatic io_access(logic wr, logic [7:0] a, logic [7:0] d);
      @(negedge ref_clk);
      {io_wr, io_rd, io_addr, io_wdata} = {wr, !wr, a, d};
      @(negedge ref_clk);
      {io_wr, io_rd} = 2'b00;
   endtask
   // bounded wait for the next refresh; cyc is the count of clocks waited
   task automatic wait_refresh(int bound, output int cyc);
      int n0;
      n0 = n_refresh;
      cyc = 0;
      while (n_refresh == n0) begin
         @(negedge ref_clk);
         cyc++;
         if (cyc > bound) stop_test(1);
      end
   endtask
   task automatic t_reset();
      io_access(1'b0, DRC_CTRL_ADDR, 8'h00);
      check("read valid", 8'h01, {7'h00, io_rdata_valid});
      check("reset value", DRC_CTRL_RESET, io_rdata);
      io_access(1'b0, 8'h35, 8'h00);
      check("unmapped valid", 8'h00, {7'h00, io_rdata_valid});
      $display("reset test done");
   endtask
   task automatic t_interval();
      logic [7:0] d, r;
      int c;
      for (int k = 0; k < 4; k++) begin
         wait_refresh(200, c);
         repeat (4) @(negedge ref_clk);
         d = {1'b1, k[0], 4'hF, k[1:0]};
         io_access(1'b1, DRC_CTRL_ADDR, d);
         io_access(1'b0, DRC_CTRL_ADDR, 8'h00);
         check("masked read", d & DRC_CTRL_WMASK, io_rdata);
         wait_refresh(200, c);
         r = last_row;
         wait_refresh(200, c);
         check("interval", 8'(10 << k), 8'(c));
         check("row step", r + 8'h01, last_row);
      end
      $display("interval test done");
   endtask
   // each hold-off blocks refresh; bus return follows the timer (80 clocks,
   // 200 held, so 40 more), sleep and wait release serve the pending one
   task automatic t_hold();
      logic [7:0] r;
      int c, n0;
      for (int k = 0; k < 3; k++) begin
         wait_refresh(200, c);
         r = last_row;
         n0 = n_refresh;
         {bus_request_in, sleep_mode, wait_active} = 3'b100 >> k;
         repeat (200) @(negedge ref_clk);
         check("held count", 8'(n0), 8'(n_refresh));
         {bus_request_in, sleep_mode, wait_active} = 3'b000;
         wait_refresh(90, c);
         if (k == 0) check("bus return phase", 8'd40, 8'(c));
         else check("pending served", 8'h01, 8'(c <= 6));
         check("row after hold", r + 8'h01, last_row);
      end
      $display("hold test done");
   endtask
   task automatic t_off();
      int c, n0;
      io_access(1'b1, DRC_CTRL_ADDR, 8'h40);
      repeat (5) @(negedge ref_clk);
      n0 = n_refresh;
      repeat (200) @(negedge ref_clk);
      check("off count", 8'(n0), 8'(n_refresh));
      io_access(1'b1, DRC_CTRL_ADDR, DRC_CTRL_RESET);
      wait_refresh(20, c);
      $display("off test done");
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // cycle_end stays high so every machine cycle boundary is a start point
   initial begin
      {reset_n, io_wr, io_rd, bus_request_in, sleep_mode, wait_active} = 6'h00;
      {io_addr, io_wdata, cycle_end} = 17'h0_0001;
      {err_count, n_compared} = 64'h0;
      repeat (4) @(negedge ref_clk);
      reset_n = 1'b1;
      t_reset();
      t_interval();
      t_hold();
      t_off();
      stop_test(1'b0);
   end
endmodule
